/* File: tps_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants of the set point one parameter bank.
// ----------------------------------------------------------------------------
package tps_pkg;
  // Parameter indices seen by the fieldbus master.
  localparam logic [15:0] IDX_HIGH_FLAG = 16'h0800;
  localparam logic [15:0] IDX_LOW_FLAG = 16'h0801;
  localparam logic [15:0] IDX_ALL_FLAGS = 16'h0810;
  localparam logic [15:0] IDX_HIGH_ARM = 16'h0811;
  localparam logic [15:0] IDX_LOW_ARM = 16'h0812;
  localparam logic [15:0] IDX_UPPER_LIM = 16'h0813;
  localparam logic [15:0] IDX_SRC_SEL = 16'h0814;
  // Bit positions inside the flag, arm and aggregate words.
  localparam int ARM_BIT = 0;
  localparam int FLAG_BIT = 0;
  localparam int ALL_SP1_HIGH = 0;
  localparam int ALL_SP1_LOW = 1;
  localparam int ALL_SP2_HIGH = 2;
  localparam int ALL_SP2_LOW = 3;
  // Source selector codes; anything but the ratio code means standard mode.
  localparam logic [15:0] SRC_RATIO = 16'h0200;
  localparam logic [15:0] SRC_STD_RST = 16'h0829;
  // Reset values of the writable parameters.
  localparam logic [7:0] ARM_RST = 8'h00;
  localparam logic [31:0] LIMIT_RST = 32'h00000000;
  // Pressure unit codes chosen by the master and their factors to mbar.
  localparam logic [1:0] UNIT_MBAR = 2'h0;
  localparam logic [1:0] UNIT_PA = 2'h1;
  localparam logic [1:0] UNIT_TORR = 2'h2;
  localparam logic [31:0] F_ONE = 32'h3F800000;
  localparam logic [31:0] F_PA_TO_MBAR = 32'h3C23D70A;
  localparam logic [31:0] F_TORR_TO_MBAR = 32'h3FAAA6F4;
  // Single precision field layout.
  localparam int EXP_BIAS = 127;
  localparam logic [7:0] EXP_MAX = 8'hFF;
endpackage
`default_nettype wire

/* File: tps_fmul_if.sv */
`default_nettype none
// ----------------------------------------------------------------------------
// Operands and product of one single precision multiplier.
// ----------------------------------------------------------------------------
interface tps_fmul_if;
  logic [31:0] op_a; // First factor.
  logic [31:0] op_b; // Second factor.
  logic [31:0] prod; // Truncated product.
  modport user (output op_a, output op_b, input prod);
  modport unit (input op_a, input op_b, output prod);
endinterface
`default_nettype wire

/* File: tps_fmul.sv */
`default_nettype none
// ----------------------------------------------------------------------------
// Combinational single precision multiplier.
// ----------------------------------------------------------------------------
// Denormal inputs and underflow give zero, overflow gives infinity, and the
// mantissa is truncated; that is ample for set point thresholds.
module tps_fmul (
  tps_fmul_if.unit mul
);
  logic [23:0] man_a; // Mantissa of the first factor with hidden one.
  logic [23:0] man_b; // Mantissa of the second factor with hidden one.
  logic [47:0] man_p; // Full mantissa product.
  logic [9:0] exp_b; // Biased exponent of the product before bias removal.
  logic sgn; // Sign of the product.

  // Product assembly with normalisation by one place at most.
  always_comb begin
    man_a = {1'b1, mul.op_a[22:0]};
    man_b = {1'b1, mul.op_b[22:0]};
    man_p = man_a * man_b;
    sgn = mul.op_a[31] ^ mul.op_b[31];
    exp_b = 10'({2'b00, mul.op_a[30:23]}) + 10'({2'b00, mul.op_b[30:23]})
      + 10'({9'h000, man_p[47]});
    if (mul.op_a[30:23] == 8'h00 || mul.op_b[30:23] == 8'h00) begin
      mul.prod = {sgn, 31'h00000000};
    end else if (exp_b <= 10'(tps_pkg::EXP_BIAS)) begin
      mul.prod = {sgn, 31'h00000000};
    end else if (exp_b >= 10'(tps_pkg::EXP_BIAS) + 10'({2'b00, tps_pkg::EXP_MAX})) begin
      mul.prod = {sgn, tps_pkg::EXP_MAX, 23'h000000};
    end else if (man_p[47]) begin
      mul.prod = {sgn, 8'(exp_b - 10'(tps_pkg::EXP_BIAS)), man_p[46:24]};
    end else begin
      mul.prod = {sgn, 8'(exp_b - 10'(tps_pkg::EXP_BIAS)), man_p[45:23]};
    end
  end
endmodule
`default_nettype wire

/* File: tps_trip_point_one.sv */
`default_nettype none
// Notes on behaviour
// RULE1: Aggregate word bits 0,1 mirror set point one.
// RULE2: Aggregate word bits 2,3 mirror set point two.
// RULE3: High flag bit 0 shows high trip state.
// RULE4: Low flag bit 0 reads zero when clear.
// RULE5: Low flag bit 0 reads one when tripped.
// RULE6: High arm bit 0 disables or enables high trip.
// RULE7: Low arm bit 0 enables or disables low trip.
// RULE8: Standard mode uses stored limit as high threshold.
// RULE9: Limit stored in mbar, converted from master unit.
// RULE10: High trip when pressure exceeds high threshold.
// RULE11: Low trip when pressure falls below low threshold.
// RULE12: Ratio mode threshold is percentage times piezo value.
// RULE13: Disarmed trip holds its flags at zero.

// ----------------------------------------------------------------------------
// Set point one parameter bank and trip evaluation.
// ----------------------------------------------------------------------------
module tps_trip_point_one #(
  parameter int ARM_W = 8 // Width of the arm parameters.
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] param_index,
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [31:0] param_wdata,
  output logic [31:0] param_rdata,
  output logic param_ack,
  output logic param_err,
  input wire logic [1:0] unit_sel,
  input wire logic [31:0] pressure_mbar,
  input wire logic [31:0] piezo_mbar,
  input wire logic [31:0] pct_upper_sp1,
  input wire logic [31:0] lower_threshold_sp1,
  input wire logic sp2_high_trip,
  input wire logic sp2_low_trip,
  output logic high_trip_sp1,
  output logic low_trip_sp1
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (ARM_W < 1 || ARM_W > 32) begin : g_bad_arm_w
    $error("ARM_W must lie between 1 and 32");
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // True when float a is strictly greater than float b; both zeros are equal.
  function automatic logic f_gt(input logic [31:0] a, input logic [31:0] b);
    logic res;
    res = 1'b0;
    if (a[30:0] == 31'h0 && b[30:0] == 31'h0) begin
      res = 1'b0;
    end else if (a[31] != b[31]) begin
      res = !a[31];
    end else if (!a[31]) begin
      res = a[30:0] > b[30:0];
    end else begin
      res = a[30:0] < b[30:0];
    end
    return res;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [ARM_W-1:0] high_arm_ff, nxt_high_arm; // High trip arm parameter.
  logic [ARM_W-1:0] low_arm_ff, nxt_low_arm; // Low trip arm parameter.
  logic [31:0] limit_ff, nxt_limit; // High limit kept in mbar.
  logic [15:0] src_ff, nxt_src; // Threshold source selector.
  logic high_ff, nxt_high; // High trip flag.
  logic low_ff, nxt_low; // Low trip flag.
  logic [31:0] rdata_ff, nxt_rdata; // Read answer.
  logic ack_ff, nxt_ack; // Access accepted.
  logic err_ff, nxt_err; // Access refused.
  logic [31:0] upper_thr; // Active high threshold in mbar.
  logic [31:0] unit_factor; // Factor from the master unit to mbar.
  logic [31:0] all_word; // Aggregate trip word.
  logic idx_known; // Index names a parameter of this bank.
  logic idx_ro; // Index names a read-only parameter.

  // --------------------------------------------------------------------------
  // Multipliers
  // --------------------------------------------------------------------------
  tps_fmul_if conv_if (); // Unit conversion of a written limit.
  tps_fmul_if ratio_if (); // Percentage times piezo value.

  tps_fmul u_conv (
    .mul(conv_if.unit)
  );

  tps_fmul u_ratio (
    .mul(ratio_if.unit)
  );

  // Unit factor chosen by the master's current pressure unit.
  always_comb begin
    case (unit_sel)
      tps_pkg::UNIT_PA: unit_factor = tps_pkg::F_PA_TO_MBAR;
      tps_pkg::UNIT_TORR: unit_factor = tps_pkg::F_TORR_TO_MBAR;
      default: unit_factor = tps_pkg::F_ONE;
    endcase
  end

  // Operands of both multipliers.
  always_comb begin
    conv_if.op_a = param_wdata; // RULE9
    conv_if.op_b = unit_factor;
    ratio_if.op_a = pct_upper_sp1; // RULE12
    ratio_if.op_b = piezo_mbar;
  end

  // Threshold source: ratio mode takes the product, else the stored limit.
  always_comb begin
    if (src_ff == tps_pkg::SRC_RATIO) begin
      upper_thr = ratio_if.prod; // RULE12
    end else begin
      upper_thr = limit_ff; // RULE8
    end
  end

  // --------------------------------------------------------------------------
  // Trip evaluation
  // --------------------------------------------------------------------------
  // Flags are compared every cycle and forced low while disarmed.
  always_comb begin // RULE13
    nxt_high = high_arm_ff[tps_pkg::ARM_BIT] && f_gt(pressure_mbar, upper_thr); // RULE10
    nxt_low = low_arm_ff[tps_pkg::ARM_BIT] && f_gt(lower_threshold_sp1, pressure_mbar); // RULE11
  end

  // Aggregate word packs both set points in the low nibble.
  always_comb begin
    all_word = 32'h00000000;
    all_word[tps_pkg::ALL_SP1_HIGH] = high_ff; // RULE1
    all_word[tps_pkg::ALL_SP1_LOW] = low_ff; // RULE1
    all_word[tps_pkg::ALL_SP2_HIGH] = sp2_high_trip; // RULE2
    all_word[tps_pkg::ALL_SP2_LOW] = sp2_low_trip; // RULE2
  end

  // --------------------------------------------------------------------------
  // Parameter access
  // --------------------------------------------------------------------------
  // Index decode shared by reads and writes.
  always_comb begin
    case (param_index)
      tps_pkg::IDX_HIGH_FLAG, tps_pkg::IDX_LOW_FLAG, tps_pkg::IDX_ALL_FLAGS: begin
        idx_known = 1'b1;
        idx_ro = 1'b1;
      end
      tps_pkg::IDX_HIGH_ARM, tps_pkg::IDX_LOW_ARM, tps_pkg::IDX_UPPER_LIM,
      tps_pkg::IDX_SRC_SEL: begin
        idx_known = 1'b1;
        idx_ro = 1'b0;
      end
      default: begin
        idx_known = 1'b0;
        idx_ro = 1'b0;
      end
    endcase
  end

  // Next values of the writable parameters and the access answer.
  // A write wins over a read in the same cycle.
  always_comb begin
    nxt_high_arm = high_arm_ff;
    nxt_low_arm = low_arm_ff;
    nxt_limit = limit_ff;
    nxt_src = src_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    if (param_wr) begin
      // Writes to unknown or read-only indices are refused unchanged.
      if (!idx_known || idx_ro) begin
        nxt_err = 1'b1;
      end else begin
        nxt_ack = 1'b1;
        case (param_index)
          tps_pkg::IDX_HIGH_ARM: nxt_high_arm = param_wdata[ARM_W-1:0]; // RULE6
          tps_pkg::IDX_LOW_ARM: nxt_low_arm = param_wdata[ARM_W-1:0]; // RULE7
          tps_pkg::IDX_UPPER_LIM: nxt_limit = conv_if.prod; // RULE9
          tps_pkg::IDX_SRC_SEL: nxt_src = param_wdata[15:0];
          default: nxt_ack = 1'b1;
        endcase
      end
    end else if (param_rd) begin
      nxt_rdata = 32'h00000000;
      if (!idx_known) begin
        nxt_err = 1'b1;
      end else begin
        nxt_ack = 1'b1;
      end
      case (param_index)
        tps_pkg::IDX_HIGH_FLAG: nxt_rdata[tps_pkg::FLAG_BIT] = high_ff; // RULE3
        tps_pkg::IDX_LOW_FLAG: nxt_rdata[tps_pkg::FLAG_BIT] = low_ff; // RULE4 RULE5
        tps_pkg::IDX_ALL_FLAGS: nxt_rdata = all_word; // RULE1 RULE2
        tps_pkg::IDX_HIGH_ARM: nxt_rdata[ARM_W-1:0] = high_arm_ff;
        tps_pkg::IDX_LOW_ARM: nxt_rdata[ARM_W-1:0] = low_arm_ff;
        tps_pkg::IDX_UPPER_LIM: nxt_rdata = upper_thr;
        tps_pkg::IDX_SRC_SEL: nxt_rdata[15:0] = src_ff;
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // All state registers with synchronous reset.
  always_ff @(posedge mclk) begin
    if (reset) begin
      high_arm_ff <= ARM_W'(tps_pkg::ARM_RST);
      low_arm_ff <= ARM_W'(tps_pkg::ARM_RST);
      limit_ff <= tps_pkg::LIMIT_RST;
      src_ff <= tps_pkg::SRC_STD_RST;
      high_ff <= 1'b0;
      low_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      high_arm_ff <= nxt_high_arm;
      low_arm_ff <= nxt_low_arm;
      limit_ff <= nxt_limit;
      src_ff <= nxt_src;
      high_ff <= nxt_high;
      low_ff <= nxt_low;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
    end
  end

  // Outputs straight from flip-flops.
  always_comb begin
    param_rdata = rdata_ff;
    param_ack = ack_ff;
    param_err = err_ff;
    high_trip_sp1 = high_ff;
    low_trip_sp1 = low_ff;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_all_word_sp1: assert property ( // RULE1
    param_rd && !param_wr && param_index == tps_pkg::IDX_ALL_FLAGS
    |=> param_ack && param_rdata[1:0] == {$past(low_ff), $past(high_ff)}
  ) else $error("aggregate word set point one bits wrong");

  a_all_word_sp2: assert property ( // RULE2
    param_rd && !param_wr && param_index == tps_pkg::IDX_ALL_FLAGS
    |=> param_rdata[3:2] == {$past(sp2_low_trip), $past(sp2_high_trip)}
      && param_rdata[31:4] == 28'h0
  ) else $error("aggregate word set point two bits wrong");

  a_high_flag_read: assert property ( // RULE3
    param_rd && !param_wr && param_index == tps_pkg::IDX_HIGH_FLAG
    |=> param_rdata == {31'h0, $past(high_trip_sp1)}
  ) else $error("high flag read wrong");

  a_low_flag_zero: assert property ( // RULE4
    param_rd && !param_wr && param_index == tps_pkg::IDX_LOW_FLAG && !low_trip_sp1
    |=> param_rdata == 32'h00000000
  ) else $error("clear low flag did not read zero");

  a_low_flag_one: assert property ( // RULE5
    param_rd && !param_wr && param_index == tps_pkg::IDX_LOW_FLAG && low_trip_sp1
    |=> param_rdata == 32'h00000001
  ) else $error("set low flag did not read one");

  a_high_arm_gate: assert property ( // RULE6
    !high_arm_ff[tps_pkg::ARM_BIT] |=> !high_trip_sp1
  ) else $error("disarmed high trip asserted");

  a_low_arm_write: assert property ( // RULE7
    param_wr && param_index == tps_pkg::IDX_LOW_ARM
    |=> low_arm_ff == $past(param_wdata[ARM_W-1:0])
  ) else $error("low arm write lost");

  a_std_threshold: assert property ( // RULE8
    src_ff != tps_pkg::SRC_RATIO && high_arm_ff[tps_pkg::ARM_BIT]
    |=> high_trip_sp1 == f_gt($past(pressure_mbar), $past(limit_ff))
  ) else $error("standard mode threshold not the limit");

  a_limit_mbar: assert property ( // RULE9
    param_wr && param_index == tps_pkg::IDX_UPPER_LIM && unit_sel == tps_pkg::UNIT_MBAR
    |=> limit_ff == $past(param_wdata)
  ) else $error("mbar limit not stored unchanged");

  a_high_trip_set: assert property ( // RULE10
    high_arm_ff[tps_pkg::ARM_BIT] && f_gt(pressure_mbar, upper_thr) |=> high_trip_sp1
  ) else $error("high trip missed");

  a_low_trip_set: assert property ( // RULE11
    low_arm_ff[tps_pkg::ARM_BIT] && f_gt(lower_threshold_sp1, pressure_mbar) |=> low_trip_sp1
  ) else $error("low trip missed");

  a_ratio_threshold: assert property ( // RULE12
    src_ff == tps_pkg::SRC_RATIO && high_arm_ff[tps_pkg::ARM_BIT]
    |=> high_trip_sp1 == f_gt($past(pressure_mbar), $past(ratio_if.prod))
  ) else $error("ratio mode threshold wrong");

  a_low_arm_gate: assert property ( // RULE13
    !low_arm_ff[tps_pkg::ARM_BIT] [*2] |-> !low_trip_sp1 && !all_word[tps_pkg::ALL_SP1_LOW]
  ) else $error("disarmed low trip asserted");

  c_high_trip: cover property (!high_trip_sp1 ##1 high_trip_sp1);
  c_low_trip: cover property (!low_trip_sp1 ##1 low_trip_sp1);
  c_ratio_mode: cover property (src_ff == tps_pkg::SRC_RATIO && high_trip_sp1);
  c_refused: cover property (param_err);

endmodule
`default_nettype wire

/* File: tps_master_model.sv */
`default_nettype none
// ----------------------------------------------------------------------------
// Fieldbus master model: issues one parameter access at a time.
// ----------------------------------------------------------------------------
module tps_master_model (
  input wire logic mclk,
  output logic [15:0] param_index,
  output logic param_wr,
  output logic param_rd,
  output logic [31:0] param_wdata,
  input wire logic [31:0] param_rdata,
  input wire logic param_ack,
  input wire logic param_err
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle values are scrambled so a stale index or data word never looks valid.
  initial begin
    param_index = 16'hFFFF;
    param_wr = 1'b0;
    param_rd = 1'b0;
    param_wdata = 32'hA5A5A5A5;
  end

  // One access: a one-cycle request pulse; the registered answer appears at the
  // edge that takes the request; its acknowledge or refusal stands for that one cycle only.
  task automatic access(input logic is_wr, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd_val, output logic ack, output logic err);
    @(negedge mclk);
    param_index = idx;
    param_wr = is_wr;
    param_rd = !is_wr;
    param_wdata = wd;
    @(negedge mclk);
    // The answer is taken mid-cycle, before the pulse is released, because
    // acknowledge and refusal drop again at the following edge.
    rd_val = param_rdata;
    ack = param_ack;
    err = param_err;
    param_wr = 1'b0;
    param_rd = 1'b0;
    param_index = ~idx;
    param_wdata = ~wd;
  endtask
endmodule
`default_nettype wire

/* File: trip_point_one_status_control_tb.sv */
`default_nettype none
// ----------------------------------------------------------------------------
// Self-checking bench for the set point one parameter bank.
// ----------------------------------------------------------------------------
module trip_point_one_status_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk; // Bench clock, 40 ns period.
  logic reset; // Synchronous reset, active high.
  logic [15:0] param_index; // Index driven by the master model.
  logic param_wr; // Write pulse from the master model.
  logic param_rd; // Read pulse from the master model.
  logic [31:0] param_wdata; // Write data from the master model.
  logic [31:0] param_rdata; // Read answer.
  logic param_ack; // Access accepted.
  logic param_err; // Access refused.
  logic [1:0] unit_sel; // Master pressure unit.
  logic [31:0] pressure_mbar; // Measured pressure.
  logic [31:0] piezo_mbar; // Piezo sensor value.
  logic [31:0] pct_upper_sp1; // Ratio for ratio mode.
  logic [31:0] lower_threshold_sp1; // Low threshold.
  logic sp2_high_trip; // Set point two high flag.
  logic sp2_low_trip; // Set point two low flag.
  logic high_trip_sp1; // Set point one high flag.
  logic low_trip_sp1; // Set point one low flag.
  int n_fail; // Mismatch counter.
  int tests_run; // Comparison counter.

  tps_trip_point_one #(.ARM_W(8)) DUT (.mclk(mclk), .reset(reset), .param_index(param_index),
    .param_wr(param_wr), .param_rd(param_rd), .param_wdata(param_wdata),
    .param_rdata(param_rdata), .param_ack(param_ack), .param_err(param_err),
    .unit_sel(unit_sel), .pressure_mbar(pressure_mbar), .piezo_mbar(piezo_mbar),
    .pct_upper_sp1(pct_upper_sp1), .lower_threshold_sp1(lower_threshold_sp1),
    .sp2_high_trip(sp2_high_trip), .sp2_low_trip(sp2_low_trip),
    .high_trip_sp1(high_trip_sp1), .low_trip_sp1(low_trip_sp1));

  tps_master_model m (.mclk(mclk), .param_index(param_index), .param_wr(param_wr),
    .param_rd(param_rd), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .param_ack(param_ack), .param_err(param_err));

  // ----------------------------------------------------------------------------
  // Clock, compare and access helpers.
  // ----------------------------------------------------------------------------
  // The clock toggles every half period.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Compares two words and reports a mismatch at once.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares two single bits.
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  // Reads one index; a refused read must answer with error and zero data.
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic ok);
    logic [31:0] d;
    logic a;
    logic e;
    m.access(1'b0, idx, 32'h00000000, d, a, e);
    chk1(a, ok);
    chk1(e, !ok);
    chk32(d, ok ? exp : 32'h00000000);
  endtask

  // Writes one index and checks whether it is accepted.
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input logic ok);
    logic [31:0] d;
    logic a;
    logic e;
    m.access(1'b1, idx, wd, d, a, e);
    chk1(a, ok);
    chk1(e, !ok);
  endtask

  // Applies a pressure, lets the registered flags settle, then checks both.
  task automatic press(input logic [31:0] p, input logic exp_hi, input logic exp_lo);
    @(negedge mclk);
    pressure_mbar = p;
    repeat (2) @(posedge mclk);
    #1;
    chk1(high_trip_sp1, exp_hi);
    chk1(low_trip_sp1, exp_lo);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------------
  // Reset values, refused reads and writes to read-only places.
  task automatic t_reset();
    rd(tps_pkg::IDX_HIGH_ARM, 32'h00000000, 1'b1);
    rd(tps_pkg::IDX_LOW_ARM, 32'h00000000, 1'b1);
    rd(tps_pkg::IDX_UPPER_LIM, 32'h00000000, 1'b1);
    rd(tps_pkg::IDX_SRC_SEL, 32'h00000829, 1'b1);
    rd(tps_pkg::IDX_HIGH_FLAG, 32'h00000000, 1'b1);
    rd(tps_pkg::IDX_LOW_FLAG, 32'h00000000, 1'b1);
    rd(16'h0815, 32'h00000000, 1'b0);
    wr(tps_pkg::IDX_HIGH_FLAG, 32'h00000001, 1'b0);
    wr(tps_pkg::IDX_ALL_FLAGS, 32'h0000000F, 1'b0);
    rd(tps_pkg::IDX_HIGH_FLAG, 32'h00000000, 1'b1);
    $display("test reset done");
  endtask

  // Every combination of set point two flags lands in bits 2 and 3.
  task automatic t_aggregate();
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      sp2_high_trip = i[0];
      sp2_low_trip = i[1];
      rd(tps_pkg::IDX_ALL_FLAGS, {28'h0, i[1], i[0], 2'b00}, 1'b1);
    end
    sp2_high_trip = 1'b0;
    sp2_low_trip = 1'b0;
    $display("test aggregate done");
  endtask

  // High trip in standard mode, armed and disarmed.
  task automatic t_high();
    wr(tps_pkg::IDX_UPPER_LIM, 32'h40000000, 1'b1);
    rd(tps_pkg::IDX_UPPER_LIM, 32'h40000000, 1'b1);
    press(32'h40400000, 1'b0, 1'b0);
    wr(tps_pkg::IDX_HIGH_ARM, 32'h00000001, 1'b1);
    rd(tps_pkg::IDX_HIGH_ARM, 32'h00000001, 1'b1);
    press(32'h40000000, 1'b0, 1'b0);
    press(32'h40400000, 1'b1, 1'b0);
    rd(tps_pkg::IDX_HIGH_FLAG, 32'h00000001, 1'b1);
    rd(tps_pkg::IDX_ALL_FLAGS, 32'h00000001, 1'b1);
    wr(tps_pkg::IDX_HIGH_ARM, 32'h00000000, 1'b1);
    press(32'h40400000, 1'b0, 1'b0);
    rd(tps_pkg::IDX_ALL_FLAGS, 32'h00000000, 1'b1);
    $display("test high done");
  endtask

  // Low trip against the outside low threshold.
  task automatic t_low();
    lower_threshold_sp1 = 32'h3F000000;
    press(32'h3E800000, 1'b0, 1'b0);
    wr(tps_pkg::IDX_LOW_ARM, 32'h00000001, 1'b1);
    press(32'h3E800000, 1'b0, 1'b1);
    rd(tps_pkg::IDX_LOW_FLAG, 32'h00000001, 1'b1);
    rd(tps_pkg::IDX_ALL_FLAGS, 32'h00000002, 1'b1);
    press(32'h3F800000, 1'b0, 1'b0);
    rd(tps_pkg::IDX_LOW_FLAG, 32'h00000000, 1'b1);
    wr(tps_pkg::IDX_LOW_ARM, 32'h00000000, 1'b1);
    $display("test low done");
  endtask

  // Limits written in Pa and Torr are judged in mbar.
  task automatic t_units();
    wr(tps_pkg::IDX_HIGH_ARM, 32'h00000001, 1'b1);
    @(negedge mclk);
    unit_sel = tps_pkg::UNIT_PA;
    wr(tps_pkg::IDX_UPPER_LIM, 32'h43480000, 1'b1);
    press(32'h3FC00000, 1'b0, 1'b0);
    press(32'h40200000, 1'b1, 1'b0);
    @(negedge mclk);
    unit_sel = tps_pkg::UNIT_TORR;
    wr(tps_pkg::IDX_UPPER_LIM, 32'h3F800000, 1'b1);
    press(32'h3FA00000, 1'b0, 1'b0);
    press(32'h3FC00000, 1'b1, 1'b0);
    @(negedge mclk);
    unit_sel = tps_pkg::UNIT_MBAR;
    $display("test units done");
  endtask

  // Ratio mode: threshold is the ratio times the piezo value.
  task automatic t_ratio();
    piezo_mbar = 32'h447A0000;
    pct_upper_sp1 = 32'h3F000000;
    wr(tps_pkg::IDX_SRC_SEL, {16'h0, tps_pkg::SRC_RATIO}, 1'b1);
    rd(tps_pkg::IDX_UPPER_LIM, 32'h43FA0000, 1'b1);
    press(32'h43C80000, 1'b0, 1'b0);
    press(32'h44160000, 1'b1, 1'b0);
    wr(tps_pkg::IDX_SRC_SEL, 32'h00000829, 1'b1);
    press(32'h44160000, 1'b1, 1'b0);
    press(32'h3F800000, 1'b0, 1'b0);
    $display("test ratio done");
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------------------
  // Drives every input at time zero, resets for two cycles, runs the tests.
  initial begin
    n_fail = 0;
    tests_run = 0;
    reset = 1'b1;
    unit_sel = tps_pkg::UNIT_MBAR;
    pressure_mbar = 32'h00000000;
    piezo_mbar = 32'h00000000;
    pct_upper_sp1 = 32'h00000000;
    lower_threshold_sp1 = 32'h00000000;
    sp2_high_trip = 1'b0;
    sp2_low_trip = 1'b0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    t_reset();
    t_aggregate();
    t_high();
    t_low();
    t_units();
    t_ratio();
    end_of_test();
  end

  // Cuts a hang short well beyond the hundred or so cycles the tests need.
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
